// File: hdl/tms_pkg.sv
// Constants, types and helpers of the two-wire management slave
// Functional notes
// [RULE1] Sample SDA on SCL rise; change driven SDA after SCL fall.
// [RULE2] Module may hold SCL low; host waits while it is low.
// [RULE3] SDA is only pulled low or released, never driven high.
// [RULE4] Module is only a slave; host generates SCL and starts transfers.
// [RULE5] Respond only to the fixed device address A0h.
// [RULE6] Acknowledge the address only when it matches and select is low.
// [RULE7] SDA changing while SCL high is a START or STOP.
// [RULE8] START is SDA falling with SCL high; address reception follows.
// [RULE9] STOP is SDA rising with SCL high; module returns to idle.
// [RULE10] All words are eight bits, most significant bit first.
// [RULE11] Transmitter releases SDA for the ack bit; receiver pulls low.
// [RULE12] Acknowledge each matched address byte and every write data byte.
// [RULE13] Host acks each read byte but the last, then sends STOP.
// [RULE14] Bus recovery: clocks with SDA high then START reset the interface.
// [RULE15] Recovery resets only the serial interface logic.
// [RULE16] Every operation starts with an address byte right after START.
// [RULE17] Address LSB one means read, zero means write.
// [RULE18] Transmit disable acts within 100 ms; release within 400 ms.
// [RULE19] Receive output disable set or cleared acts within 100 ms.
// [RULE20] Squelch disable change acts on both paths within 100 ms.
// [RULE21] Latency counts from SCL fall following the write's STOP.
// [RULE22] Receive squelch follows receive signal loss within 80 us.
// [RULE23] Transmit squelch follows transmit signal loss within 400 ms.
// [RULE24] Byte counter increments per word, wraps inside its 128-byte page.
// [RULE25] Repeated START after address write leaves counter unincremented.
// [RULE26] Read keeps sending words while host acks; stops on NACK.
// [RULE27] Mismatch or deselected: SDA released, ignored until next START.
// [RULE28] Edge and condition detection use filtered synchronised SCL, SDA.
package tms_pkg;
   localparam logic [7:0] DEV_ADDR    = 8'ha0;
   localparam int         MEM_DEPTH   = 256;
   localparam int         PAGE_BITS   = 7;
   localparam logic [3:0] BITS_WORD   = 4'h8;
   localparam logic [7:0] CTRL_TXDIS  = 8'h56;
   localparam logic [7:0] CTRL_RXDIS  = 8'h57;
   localparam logic [7:0] CTRL_SQDIS  = 8'h58;
   localparam logic [7:0] CNT_RESET   = 8'h00;
   localparam int         FILT_LEN    = 3;

   typedef enum logic [6:0] {
      st_idle  = 7'h01,
      st_dev   = 7'h02,
      st_dack  = 7'h04,
      st_wbyte = 7'h08,
      st_wack  = 7'h10,
      st_rbyte = 7'h20,
      st_rack  = 7'h40
   } tms_state_t;

   // Increment that stays inside the current page
   function automatic logic [7:0] next_addr(input logic [7:0] a);
      next_addr = {a[7:PAGE_BITS], a[PAGE_BITS-1:0] + 7'h01};
   endfunction
endpackage

// File: hdl/tms_mem_if.sv
// Carrier between the serial engine and its byte memory
`timescale 1ns/1ps
interface tms_mem_if;
   logic       we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport m (output we, output addr, output wdata, input rdata);
   modport s (input we, input addr, input wdata, output rdata);
endinterface

// File: hdl/tms_mem.sv
// Byte memory behind the management interface, registered read
`timescale 1ns/1ps
module tms_mem #(
   parameter int DEPTH = tms_pkg::MEM_DEPTH // Bytes held
) (
   input wire logic clk,  // System clock
   tms_mem_if.s     mif   // Engine side
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (mif.we) begin
         mem[mif.addr] <= mif.wdata;
      end
      mif.rdata <= mem[mif.addr];
   end
endmodule

// File: hdl/tms_top.sv
// Two-wire management slave: framing, addressing, counter, controls
`timescale 1ns/1ps
module tms_top #(
   parameter int LANES = 4 // Transceiver lanes
) (
   input  wire logic             clk,             // 25 MHz clock
   input  wire logic             rstn,            // Sync reset, low
   input  wire logic             scl_in,          // SCL pin level
   output logic                  scl_out,         // SCL pull value
   output logic                  scl_oe_n,        // Low: hold SCL low
   input  wire logic             sda_in,          // SDA pin level
   output logic                  sda_out,         // SDA pull value
   output logic                  sda_oe_n,        // Low: pull SDA low
   input  wire logic             module_select_n, // Select pin, low
   input  wire logic             stretch_req,     // Ask to stretch
   input  wire logic [LANES-1:0] rx_los,          // Rx signal lost
   input  wire logic [LANES-1:0] tx_los,          // Tx signal lost
   output logic      [LANES-1:0] tx_disable,      // Transmitter off
   output logic      [LANES-1:0] rx_out_disable,  // Rx output off
   output logic      [LANES-1:0] squelch_disable, // Auto squelch off
   output logic      [LANES-1:0] rx_squelch,      // Rx output squelched
   output logic      [LANES-1:0] tx_squelch       // Tx output squelched
);
   localparam int FL = tms_pkg::FILT_LEN;

   logic             scl_s1, scl_s2, sda_s1, sda_s2, sel_s1, sel_n;
   logic [LANES-1:0] rlos_s1, rlos, tlos_s1, tlos;
   logic [FL-1:0]    scl_h, sda_h;
   logic             scl_f, sda_f, scl_p, sda_p;
   tms_pkg::tms_state_t state, next_state;
   logic [3:0]       bitcnt, next_bitcnt;
   logic [7:0]       shreg, next_shreg;
   logic [7:0]       addr_cnt, next_cnt;
   logic             first, next_first;
   logic             drv, next_drv;
   logic             mem_we;
   logic             ctrl_wr, arm;
   logic [LANES-1:0] pend_tx, pend_rx, pend_sq;

   tms_mem_if mif ();

   tms_mem #(
      .DEPTH (tms_pkg::MEM_DEPTH)
   ) u_mem (
      .clk (clk),
      .mif (mif)
   );

   // Pins come from the host's domain
   always_ff @(posedge clk) begin
      scl_s1  <= scl_in;
      scl_s2  <= scl_s1;
      sda_s1  <= sda_in;
      sda_s2  <= sda_s1;
      sel_s1  <= module_select_n;
      sel_n   <= sel_s1;
      rlos_s1 <= rx_los;
      rlos    <= rlos_s1;
      tlos_s1 <= tx_los;
      tlos    <= tlos_s1;
   end

   // Level accepted only after FL equal samples, spikes are dropped
   always_ff @(posedge clk) begin
      if (!rstn) begin
         scl_h <= '1;
         sda_h <= '1;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_h <= {scl_h[FL-2:0], scl_s2};
         sda_h <= {sda_h[FL-2:0], sda_s2};
         if (&scl_h || ~|scl_h) begin
            scl_f <= scl_h[FL-1]; // RULE28
         end
         if (&sda_h || ~|sda_h) begin
            sda_f <= sda_h[FL-1]; // RULE28
         end
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end

   wire scl_rise = scl_f & ~scl_p;
   wire scl_fall = ~scl_f & scl_p;
   wire start_c  = scl_f & scl_p & sda_p & ~sda_f; // RULE7 RULE8
   wire stop_c   = scl_f & scl_p & ~sda_p & sda_f; // RULE7 RULE9
   wire word_end = scl_fall && (bitcnt == tms_pkg::BITS_WORD);
   wire addr_hit = (shreg[7:1] == tms_pkg::DEV_ADDR[7:1]) && !sel_n; // RULE5
   wire is_read  = shreg[0];
   wire host_ack = ~sda_f;
   wire ctrl_hit = (addr_cnt == tms_pkg::CTRL_TXDIS)
                || (addr_cnt == tms_pkg::CTRL_RXDIS)
                || (addr_cnt == tms_pkg::CTRL_SQDIS);

   assign mif.we    = mem_we;
   assign mif.addr  = addr_cnt;
   assign mif.wdata = shreg;

   always_comb begin
      next_state  = state;
      next_bitcnt = bitcnt;
      next_shreg  = shreg;
      next_cnt    = addr_cnt;
      next_first  = first;
      next_drv    = drv;
      mem_we      = 1'b0;
      if (start_c) begin
         // Also ends any hung transfer: bus recovery
         next_state  = tms_pkg::st_dev; // RULE8 RULE14 RULE16
         next_bitcnt = 4'h0;
         next_drv    = 1'b0; // RULE14
      end else if (stop_c) begin
         next_state = tms_pkg::st_idle; // RULE9
         next_drv   = 1'b0;
      end else begin
         unique case (state)
            tms_pkg::st_idle: begin
               next_drv = 1'b0; // RULE27
            end
            tms_pkg::st_dev, tms_pkg::st_wbyte: begin
               if (scl_rise) begin
                  next_shreg  = {shreg[6:0], sda_f}; // RULE1 RULE10
                  next_bitcnt = bitcnt + 4'h1;
               end else if (word_end) begin
                  if (state == tms_pkg::st_dev) begin
                     if (addr_hit) begin
                        next_drv   = 1'b1; // RULE6 RULE12
                        next_state = tms_pkg::st_dack;
                     end else begin
                        next_state = tms_pkg::st_idle; // RULE27
                     end
                  end else begin
                     next_drv   = 1'b1; // RULE11 RULE12
                     next_state = tms_pkg::st_wack;
                     if (first) begin
                        // Address load only, no increment
                        next_cnt = shreg; // RULE25
                     end else begin
                        mem_we   = 1'b1;
                        next_cnt = tms_pkg::next_addr(addr_cnt); // RULE24
                     end
                  end
               end
            end
            tms_pkg::st_dack: begin
               if (scl_fall) begin
                  next_bitcnt = 4'h0;
                  if (is_read) begin
                     next_state = tms_pkg::st_rbyte; // RULE17
                     next_shreg = mif.rdata;
                     next_drv   = ~mif.rdata[7];
                  end else begin
                     next_state = tms_pkg::st_wbyte; // RULE17
                     next_first = 1'b1;
                     next_drv   = 1'b0;
                  end
               end
            end
            tms_pkg::st_wack: begin
               if (scl_fall) begin
                  next_state  = tms_pkg::st_wbyte;
                  next_bitcnt = 4'h0;
                  next_first  = 1'b0;
                  next_drv    = 1'b0;
               end
            end
            tms_pkg::st_rbyte: begin
               if (scl_fall) begin
                  next_bitcnt = bitcnt + 4'h1;
                  if (bitcnt == 4'h7) begin
                     next_drv   = 1'b0; // RULE11
                     next_state = tms_pkg::st_rack;
                     next_cnt   = tms_pkg::next_addr(addr_cnt); // RULE24
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_drv   = ~shreg[6]; // RULE1 RULE3
                  end
               end
            end
            tms_pkg::st_rack: begin
               if (scl_fall) begin
                  next_bitcnt = 4'h0;
                  if (host_ack) begin
                     next_state = tms_pkg::st_rbyte; // RULE26
                     next_shreg = mif.rdata;
                     next_drv   = ~mif.rdata[7];
                  end else begin
                     next_state = tms_pkg::st_idle; // RULE13 RULE26
                     next_drv   = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // Serial state; recovery touches nothing outside this group
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state    <= tms_pkg::st_idle;
         bitcnt   <= 4'h0;
         shreg    <= 8'h00;
         first    <= 1'b0;
         drv      <= 1'b0;
         addr_cnt <= tms_pkg::CNT_RESET;
      end else begin
         state    <= next_state; // RULE4 RULE15
         bitcnt   <= next_bitcnt;
         shreg    <= next_shreg;
         first    <= next_first;
         drv      <= next_drv;
         addr_cnt <= next_cnt;
      end
   end

   // Only ever pulls low; the pull-up sets the high level
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sda_out  <= 1'b0;
         sda_oe_n <= 1'b1;
         scl_out  <= 1'b0;
         scl_oe_n <= 1'b1;
      end else begin
         sda_out  <= 1'b0; // RULE3
         sda_oe_n <= ~next_drv; // RULE3
         scl_out  <= 1'b0;
         // Stretch starts only while filtered SCL is low, which trails the pin level by several cycles
         scl_oe_n <= ~(stretch_req && (!scl_f || !scl_oe_n)); // RULE2
      end
   end

   // Control bytes take effect at the SCL fall after the STOP
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_wr         <= 1'b0;
         arm             <= 1'b0;
         pend_tx         <= '0;
         pend_rx         <= '0;
         pend_sq         <= '0;
         tx_disable      <= '0;
         rx_out_disable  <= '0;
         squelch_disable <= '0;
      end else begin
         if (mem_we && ctrl_hit) begin
            ctrl_wr <= 1'b1;
         end else if (stop_c) begin
            ctrl_wr <= 1'b0;
         end
         if (mem_we && addr_cnt == tms_pkg::CTRL_TXDIS) begin
            pend_tx <= shreg[LANES-1:0];
         end
         if (mem_we && addr_cnt == tms_pkg::CTRL_RXDIS) begin
            pend_rx <= shreg[LANES-1:0];
         end
         if (mem_we && addr_cnt == tms_pkg::CTRL_SQDIS) begin
            pend_sq <= shreg[LANES-1:0];
         end
         if (stop_c && ctrl_wr) begin
            arm <= 1'b1;
         end else if (scl_fall) begin
            arm <= 1'b0;
         end
         if (arm && scl_fall) begin
            tx_disable      <= pend_tx; // RULE18 RULE21
            rx_out_disable  <= pend_rx; // RULE19 RULE21
            squelch_disable <= pend_sq; // RULE20 RULE21
         end
      end
   end

   // Squelch follows loss in a few cycles, far inside the limits
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_squelch <= '0;
         tx_squelch <= '0;
      end else begin
         rx_squelch <= rlos & ~squelch_disable; // RULE22 RULE20
         tx_squelch <= tlos & ~squelch_disable; // RULE23 RULE20
      end
   end

   sequence s_addr_done;
      state == tms_pkg::st_dev && word_end && !start_c && !stop_c;
   endsequence

   sequence s_wdata_done;
      state == tms_pkg::st_wbyte && word_end && !first
         && !start_c && !stop_c;
   endsequence

   AST_DRIVE_ON_FALL: assert property ( // RULE1
      @(posedge clk) disable iff (!rstn)
      $changed(sda_oe_n) |-> $past(scl_fall || start_c || stop_c
         || state == tms_pkg::st_idle))
      else $error("SDA drive changed outside SCL fall");

   AST_PULL_ONLY: assert property ( // RULE3
      @(posedge clk) disable iff (!rstn)
      sda_out == 1'b0 && scl_out == 1'b0)
      else $error("Pin driven high");

   AST_STRETCH: assert property ( // RULE2
      @(posedge clk) disable iff (!rstn)
      !scl_oe_n |-> $past(stretch_req))
      else $error("SCL held without request");

   AST_ADDR_ACK: assert property ( // RULE6
      @(posedge clk) disable iff (!rstn)
      s_addr_done ##0 addr_hit |=> !sda_oe_n
         && state == tms_pkg::st_dack)
      else $error("Matched address not acknowledged");

   AST_ADDR_IGNORE: assert property ( // RULE27
      @(posedge clk) disable iff (!rstn)
      s_addr_done ##0 !addr_hit |=> sda_oe_n
         && state == tms_pkg::st_idle)
      else $error("Foreign address not ignored");

   AST_START_RESET: assert property ( // RULE14
      @(posedge clk) disable iff (!rstn)
      start_c |=> state == tms_pkg::st_dev && bitcnt == 4'h0
         && sda_oe_n)
      else $error("START did not reset the interface");

   AST_STOP_IDLE: assert property ( // RULE9
      @(posedge clk) disable iff (!rstn)
      stop_c |=> state == tms_pkg::st_idle ##1 sda_oe_n)
      else $error("STOP did not return to idle");

   AST_WRAP: assert property ( // RULE24
      @(posedge clk) disable iff (!rstn)
      s_wdata_done |=> addr_cnt[6:0] == $past(addr_cnt[6:0]) + 7'h01
         && addr_cnt[7] == $past(addr_cnt[7]))
      else $error("Counter step or page wrap wrong");

   AST_CTRL_APPLY: assert property ( // RULE21
      @(posedge clk) disable iff (!rstn)
      arm && scl_fall |=> tx_disable == $past(pend_tx)
         && rx_out_disable == $past(pend_rx)
         && squelch_disable == $past(pend_sq))
      else $error("Control bits not applied");

   AST_RX_SQUELCH: assert property ( // RULE22
      @(posedge clk) disable iff (!rstn)
      $rose(rx_los[0]) && !squelch_disable[0] ##1 !squelch_disable[0]
         [*3] |-> rx_squelch[0])
      else $error("Rx squelch late");
endmodule

// File: verif/tms_host_model.sv
// Host bus master model that clocks the two-wire bus
`timescale 1ns/1ps
module tms_host_model (
   input  wire logic clk,      // System clock
   input  wire logic scl,      // SCL wire level
   input  wire logic sda,      // SDA wire level
   output logic      scl_oe_n, // Low: pull SCL low
   output logic      sda_oe_n  // Low: pull SDA low
);
   int stalls;
   initial begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
      stalls   = 0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Data moves mid-low so it is settled long before the rise
   task automatic xfer_bit(input logic d, output logic q);
      int n;
      n = 0;
      tick(6);
      sda_oe_n = d;
      tick(6);
      scl_oe_n = 1'b1;
      while (scl !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      if (n >= 400) begin
         stalls++;
      end
      tick(4);
      q = sda;
      tick(4);
      scl_oe_n = 1'b0;
   endtask
   task automatic start();
      tick(6);
      sda_oe_n = 1'b1;
      tick(6);
      scl_oe_n = 1'b1;
      tick(8);
      sda_oe_n = 1'b0;
      tick(8);
      scl_oe_n = 1'b0;
   endtask
   task automatic stop();
      tick(6);
      sda_oe_n = 1'b0;
      tick(6);
      scl_oe_n = 1'b1;
      tick(8);
      sda_oe_n = 1'b1;
      tick(8);
   endtask
   task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                            output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(d[i], q[i]);
      end
      xfer_bit(ack_in, ack);
   endtask
   task automatic recover(output int highs);
      logic q;
      highs = 0;
      for (int i = 0; i < 9; i++) begin
         xfer_bit(1'b1, q);
         if (q === 1'b1) begin
            highs++;
         end
      end
      start();
   endtask
endmodule

// File: verif/tb_two_wire_mgmt_slave.sv
// Self-checking bench of the two-wire management slave
`timescale 1ns/1ps
module tb_two_wire_mgmt_slave;
   logic       clk;
   logic       rstn;
   logic       module_select_n;
   logic       stretch_req;
   logic [3:0] rx_los, tx_los;
   logic       scl_w, sda_w;
   logic       scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic       h_scl_oe_n, h_sda_oe_n;
   logic [3:0] tx_disable, rx_out_disable, squelch_disable;
   logic [3:0] rx_squelch, tx_squelch;
   int         num_errors, compares, cycles, highs;
   logic [7:0] q;
   logic       ack;

   // Pull-ups on both wires: any enabled party wins low
   assign scl_w = h_scl_oe_n & scl_oe_n;
   assign sda_w = h_sda_oe_n & sda_oe_n;

   initial clk = 1'b0;
   always #20 clk = ~clk;

   tms_top u_tms_top (
      .clk(clk), .rstn(rstn), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .module_select_n(module_select_n),
      .stretch_req(stretch_req), .rx_los(rx_los), .tx_los(tx_los),
      .tx_disable(tx_disable), .rx_out_disable(rx_out_disable),
      .squelch_disable(squelch_disable), .rx_squelch(rx_squelch),
      .tx_squelch(tx_squelch));
   tms_host_model u_tms_host_model (
      .clk(clk), .scl(scl_w), .sda(sda_w),
      .scl_oe_n(h_scl_oe_n), .sda_oe_n(h_sda_oe_n));

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] d, input logic exp_ack);
      u_tms_host_model.xfer_byte(d, 1'b1, q, ack);
      check("ack", {7'h00, ack}, {7'h00, exp_ack});
   endtask
   task automatic rd(input logic host_ack, input logic [7:0] exp);
      u_tms_host_model.xfer_byte(8'hff, host_ack, q, ack);
      check("rdata", q, exp);
   endtask
   // Dummy write loads the pointer, repeated start turns to read
   task automatic set_ptr(input logic [7:0] a);
      u_tms_host_model.start();
      wr(tms_pkg::DEV_ADDR, 1'b0);
      wr(a, 1'b0);
      u_tms_host_model.start();
      wr(tms_pkg::DEV_ADDR | 8'h01, 1'b0);
   endtask
   task automatic ctl(input logic [7:0] a, b, c);
      check("tx_disable", {4'h0, tx_disable}, a);
      check("rx_out_disable", {4'h0, rx_out_disable}, b);
      check("squelch_disable", {4'h0, squelch_disable}, c);
   endtask

   // Whole run is near 8.5k cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 60000) begin
         num_errors++;
         conclude();
      end
   end

   initial begin
      num_errors = 0;
      compares = 0;
      cycles = 0;
      rstn = 1'b0;
      module_select_n = 1'b0;
      stretch_req = 1'b0;
      rx_los = 4'h0;
      tx_los = 4'h0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      u_tms_host_model.tick(8);
      check("sda_oe_n", {7'h00, sda_oe_n}, 8'h01);
      check("scl_oe_n", {7'h00, scl_oe_n}, 8'h01);
      check("pins", {6'h00, scl_out, sda_out}, 8'h00);
      ctl(8'h00, 8'h00, 8'h00);
      // Squelch active on every lane before any control write
      rx_los = 4'h5;
      tx_los = 4'ha;
      u_tms_host_model.tick(10);
      check("rx_squelch", {4'h0, rx_squelch}, 8'h05);
      check("tx_squelch", {4'h0, tx_squelch}, 8'h0a);
      rx_los = 4'h0;
      tx_los = 4'h0;
      u_tms_host_model.tick(10);
      check("rx_squelch", {4'h0, rx_squelch}, 8'h00);
      // Sequential write, one byte of it stretched by the module
      u_tms_host_model.start();
      wr(tms_pkg::DEV_ADDR, 1'b0);
      wr(8'h10, 1'b0);
      fork
         wr(8'h11, 1'b0);
         begin
            @(negedge scl_w);
            u_tms_host_model.tick(8);
            stretch_req = 1'b1;
            u_tms_host_model.tick(3);
            check("stretch", {7'h00, scl_oe_n}, 8'h00);
            check("pins", {6'h00, scl_out, sda_out}, 8'h00);
            u_tms_host_model.tick(40);
            stretch_req = 1'b0;
         end
      join
      wr(8'h22, 1'b0);
      wr(8'h33, 1'b0);
      u_tms_host_model.stop();
      set_ptr(8'h10);
      rd(1'b0, 8'h11);
      rd(1'b0, 8'h22);
      rd(1'b1, 8'h33);
      u_tms_host_model.stop();
      // Writes and reads wrap inside the low page
      u_tms_host_model.start();
      wr(tms_pkg::DEV_ADDR, 1'b0);
      wr(8'h7f, 1'b0);
      wr(8'h5a, 1'b0);
      wr(8'ha5, 1'b0);
      wr(8'h3c, 1'b0);
      u_tms_host_model.stop();
      set_ptr(8'h7f);
      rd(1'b0, 8'h5a);
      rd(1'b1, 8'ha5);
      u_tms_host_model.stop();
      u_tms_host_model.start();
      wr(tms_pkg::DEV_ADDR | 8'h01, 1'b0);
      rd(1'b1, 8'h3c);
      u_tms_host_model.stop();
      // Foreign addresses and a deselected module stay silent
      for (int i = 0; i < 3; i++) begin
         module_select_n = (i == 2);
         u_tms_host_model.start();
         wr((i == 0) ? 8'ha2 : (i == 1) ? 8'h20 : 8'ha0, 1'b1);
         wr(8'h00, 1'b1);
         u_tms_host_model.stop();
      end
      module_select_n = 1'b0;
      // Control bytes act once the next transfer clocks SCL
      u_tms_host_model.start();
      wr(tms_pkg::DEV_ADDR, 1'b0);
      wr(tms_pkg::CTRL_TXDIS, 1'b0);
      wr(8'h05, 1'b0);
      wr(8'h0a, 1'b0);
      wr(8'h03, 1'b0);
      u_tms_host_model.stop();
      u_tms_host_model.start();
      u_tms_host_model.tick(10);
      ctl(8'h05, 8'h0a, 8'h03);
      u_tms_host_model.stop();
      // Lanes 0 and 1 have auto squelch turned off
      rx_los = 4'h5;
      tx_los = 4'ha;
      u_tms_host_model.tick(10);
      check("rx_squelch", {4'h0, rx_squelch}, 8'h04);
      check("tx_squelch", {4'h0, tx_squelch}, 8'h08);
      rx_los = 4'h0;
      tx_los = 4'h0;
      u_tms_host_model.tick(10);
      check("rx_squelch", {4'h0, rx_squelch}, 8'h00);
      check("tx_squelch", {4'h0, tx_squelch}, 8'h00);
      // Hang the bus in mid read byte, then recover it
      set_ptr(8'h10);
      repeat (3) u_tms_host_model.xfer_bit(1'b1, ack);
      u_tms_host_model.recover(highs);
      check("sda_high_seen", {7'h00, highs > 0}, 8'h01);
      u_tms_host_model.stop();
      ctl(8'h05, 8'h0a, 8'h03);
      set_ptr(8'h10);
      rd(1'b1, 8'h11);
      u_tms_host_model.stop();
      check("stalls", u_tms_host_model.stalls[7:0], 8'h00);
      conclude();
   end
endmodule
